//--- design/frs_reset_sequencer.sv
// Purpose: power-on and shared-pin hardware reset sequencing for a serial flash
// Assumes: 250 MHz free-running core clock; pins arrive asynchronously
// Notes: long counts are parameters so that a simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "frs_consts.svh"
module frs_reset_sequencer
    import frs_pkg::*;
#(
    parameter int POWER_UP_CYC = `FRS_POWER_UP_CYC,
    parameter int RECOVERY_CYC = `FRS_RECOVERY_CYC,
    parameter int DESEL_CYC = `FRS_DESEL_CYC,
    parameter int DESEL_LONG_CYC = `FRS_DESEL_LONG_CYC,
    parameter int RST_PULSE_CYC = `FRS_RST_PULSE_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic supplyGood,
    input wire logic selectNPin,
    input wire logic sharedPinAIn,
    input wire logic sharedPinAPullEn,
    output logic sharedPinAOut,
    output logic sharedPinAOe,
    input wire logic quadModeEnableBit,
    input wire logic resetPinEnableBit,
    input wire logic quadReadDone,
    input wire logic softResetCmd,
    output logic deviceReady,
    output logic regRestore,
    output logic abortOps,
    output logic outputsHiZ,
    output logic commandBlock,
    output logic porFailed
);
    logic [1:0] rstSync_q;
    logic rstN;
    logic selN;
    logic pinRaw;
    logic pinLvl;
    frs_state_e state_q;
    frs_state_e state_d;
    frs_count_t timer_q;
    frs_count_t deselCnt_q;
    frs_count_t lowCnt_q;
    logic porBad_q;
    logic pinOut_q;
    logic pinOe_q;
    logic ready_q;
    logic restore_q;
    logic abort_q;
    logic hiZ_q;
    logic block_q;
    logic drive_q;
    logic selPrev_q;

    // reset release goes through two flops; the copy drives the whole design
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // an undriven pin reads high through the pull-up
    assign pinRaw = sharedPinAIn | sharedPinAPullEn;

    frs_pin_sync #(.RESET_VALUE(1'b1)) uSelSync (
        .clock(clock),
        .rstN(rstN),
        .pinIn(selectNPin),
        .pinOut(selN)
    );

    frs_pin_sync #(.RESET_VALUE(1'b1)) uPinSync (
        .clock(clock),
        .rstN(rstN),
        .pinIn(pinRaw),
        .pinOut(pinLvl)
    );

    // deselect time grows when both pin reset and quad mode are on
    logic longDesel;
    frs_count_t deselLimit;
    logic deselOver;
    logic pinIsReset;
    logic resetLow;
    logic pulseLong;
    logic timerDone;
    assign longDesel = resetPinEnableBit & quadModeEnableBit;
    assign deselLimit = longDesel ? frs_count_t'(DESEL_LONG_CYC) : frs_count_t'(DESEL_CYC);
    assign deselOver = selN && (deselCnt_q >= deselLimit);
    assign pinIsReset = deselOver || !quadModeEnableBit;
    assign resetLow = pinIsReset && !pinLvl;
    assign pulseLong = lowCnt_q >= frs_count_t'(RST_PULSE_CYC);
    assign timerDone = timer_q == '0;

    // deselect timer on the core clock, since the serial clock may be stopped
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            deselCnt_q <= '0;
        end else if (!selN) begin
            deselCnt_q <= '0;
        end else if (!deselOver) begin
            deselCnt_q <= deselCnt_q + 1'b1;
        end
    end

    // low-pulse width counter; counts only while the pin acts as reset
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            lowCnt_q <= '0;
        end else if (!resetLow) begin
            lowCnt_q <= '0;
        end else if (!pulseLong) begin
            lowCnt_q <= lowCnt_q + 1'b1;
        end
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            FRS_POR: begin
                if (supplyGood && timerDone) begin
                    state_d = pinLvl ? FRS_READY : FRS_POR_HELD;
                end
            end
            FRS_POR_HELD: begin
                if (pinLvl) begin
                    state_d = FRS_READY;
                end
            end
            FRS_READY: begin
                if (softResetCmd) begin
                    state_d = FRS_SW_RESET;
                end else if (resetLow && pulseLong) begin
                    state_d = porBad_q ? FRS_POR : FRS_HW_RESET;
                end
            end
            FRS_HW_RESET: begin
                if (timerDone) begin
                    state_d = FRS_READY;
                end
            end
            FRS_SW_RESET: begin
                if (timerDone) begin
                    state_d = FRS_READY;
                end
            end
            default: begin
                state_d = FRS_POR;
            end
        endcase
    end

    // state and interval timer; the timer loads on entry to a timed state
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            state_q <= FRS_POR;
            timer_q <= frs_count_t'(POWER_UP_CYC);
        end else begin
            state_q <= state_d;
            if (state_q == FRS_POR && !supplyGood) begin
                timer_q <= frs_count_t'(POWER_UP_CYC);
            end else if (state_d != state_q && state_d == FRS_POR) begin
                timer_q <= frs_count_t'(POWER_UP_CYC);
            end else if (state_d != state_q && state_d != FRS_READY) begin
                timer_q <= frs_count_t'(RECOVERY_CYC);
            end else if (!timerDone) begin
                timer_q <= timer_q - 1'b1;
            end
        end
    end

    // power-on counts as failed if the supply drops before the interval ends;
    // the flag survives into ready so the next pin reset reruns the full power-on
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            porBad_q <= 1'b0;
        end else if (state_q == FRS_READY && state_d == FRS_POR) begin
            porBad_q <= 1'b0;
        end else if (state_q == FRS_POR && !supplyGood &&
                timer_q != frs_count_t'(POWER_UP_CYC)) begin
            porBad_q <= 1'b1;
        end
    end

    // after a quad read, drive data line 3 high until deselect time ends
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            selPrev_q <= 1'b1;
            drive_q <= 1'b0;
        end else begin
            selPrev_q <= selN;
            if (state_q != FRS_READY || deselOver || !selN) begin
                drive_q <= 1'b0;
            end else if (selN && !selPrev_q && quadReadDone && quadModeEnableBit) begin
                drive_q <= 1'b1;
            end
        end
    end

    // registered outputs; outputsHiZ is set in any reset, but sharedPinAOe follows state_q and can stay on for its first cycle
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            pinOut_q <= 1'b1;
            pinOe_q <= 1'b0;
            ready_q <= 1'b0;
            restore_q <= 1'b0;
            abort_q <= 1'b0;
            hiZ_q <= 1'b1;
            block_q <= 1'b1;
        end else begin
            pinOut_q <= 1'b1;
            pinOe_q <= drive_q && state_q == FRS_READY;
            ready_q <= state_d == FRS_READY;
            restore_q <= state_q == FRS_READY && state_d != FRS_READY;
            abort_q <= state_d == FRS_HW_RESET;
            hiZ_q <= state_d != FRS_READY;
            block_q <= state_d != FRS_READY;
        end
    end

    assign sharedPinAOut = pinOut_q;
    assign sharedPinAOe = pinOe_q;
    assign deviceReady = ready_q;
    assign regRestore = restore_q;
    assign abortOps = abort_q;
    assign outputsHiZ = hiZ_q;
    assign commandBlock = block_q;
    assign porFailed = porBad_q;

    // checks
    chk_glitch_ignored: assert property (@(posedge clock) disable iff (!rstN)
        (state_q == FRS_READY && !pulseLong && !softResetCmd) |=> state_q == FRS_READY)
        else $error("short reset pulse started a reset");
    chk_por_ignores_pin: assert property (@(posedge clock) disable iff (!rstN)
        (state_q == FRS_POR && !timerDone) |=> state_q == FRS_POR)
        else $error("power-on left early");
    chk_hw_blocks_cmds: assert property (@(posedge clock) disable iff (!rstN)
        state_q == FRS_HW_RESET |-> commandBlock && outputsHiZ && abortOps)
        else $error("commands not blocked in reset");
    chk_hw_recovery_len: assert property (@(posedge clock) disable iff (!rstN)
        (state_q == FRS_READY && state_d == FRS_HW_RESET)
        |=> timer_q == frs_count_t'(RECOVERY_CYC))
        else $error("recovery timer not loaded");
    chk_bad_por_full: assert property (@(posedge clock) disable iff (!rstN)
        (state_q == FRS_READY && state_d != FRS_READY && !softResetCmd && porBad_q)
        |=> state_q == FRS_POR)
        else $error("failed power-on did not rerun");
    chk_held_in_reset: assert property (@(posedge clock) disable iff (!rstN)
        (state_q == FRS_POR_HELD && !pinLvl) |=> !deviceReady)
        else $error("ready while reset held");
    chk_pin_data_mode: assert property (@(posedge clock) disable iff (!rstN)
        (quadModeEnableBit && !deselOver) |=> lowCnt_q == '0)
        else $error("pin taken as reset while selected");
    chk_sw_reset_any: assert property (@(posedge clock) disable iff (!rstN)
        (state_q == FRS_READY && softResetCmd) |=> state_q == FRS_SW_RESET)
        else $error("software reset not taken");
    chk_drive_only_ready: assert property (@(posedge clock) disable iff (!rstN)
        sharedPinAOe |-> (sharedPinAOut && $past(state_q == FRS_READY)))
        else $error("pin driven low or outside ready");
    cov_hw_reset: cover property (@(posedge clock) disable iff (!rstN) state_q == FRS_HW_RESET);
    cov_por_held: cover property (@(posedge clock) disable iff (!rstN) state_q == FRS_POR_HELD);
    cov_sw_reset: cover property (@(posedge clock) disable iff (!rstN) state_q == FRS_SW_RESET);
    cov_pin_drive: cover property (@(posedge clock) disable iff (!rstN) sharedPinAOe);
endmodule
`default_nettype wire

//--- common/frs_consts.svh
// Purpose: timing and reset constants for the flash reset pin sequencer
// Assumes: core clock at 250 MHz (4 ns period)
// Notes: times are kept in their printed unit; cycle counts derive from them
`ifndef FRS_CONSTS_SVH
`define FRS_CONSTS_SVH
`define FRS_CLK_PERIOD_PS 4000
`define FRS_DESEL_NS 10
`define FRS_DESEL_LONG_NS 20
`define FRS_DESEL_CYC ((`FRS_DESEL_NS * 1000 + `FRS_CLK_PERIOD_PS - 1) / `FRS_CLK_PERIOD_PS)
`define FRS_DESEL_LONG_CYC \
    ((`FRS_DESEL_LONG_NS * 1000 + `FRS_CLK_PERIOD_PS - 1) / `FRS_CLK_PERIOD_PS)
`define FRS_RST_PULSE_NS 200
`define FRS_RST_PULSE_CYC \
    ((`FRS_RST_PULSE_NS * 1000 + `FRS_CLK_PERIOD_PS - 1) / `FRS_CLK_PERIOD_PS)
`define FRS_RECOVERY_US 35
`define FRS_RECOVERY_CYC \
    ((`FRS_RECOVERY_US * 1000000 + `FRS_CLK_PERIOD_PS - 1) / `FRS_CLK_PERIOD_PS)
`define FRS_POWER_UP_US 300
`define FRS_POWER_UP_CYC \
    ((`FRS_POWER_UP_US * 1000000 + `FRS_CLK_PERIOD_PS - 1) / `FRS_CLK_PERIOD_PS)
`define FRS_CNT_W 20
`endif

//--- common/frs_pkg.sv
// Purpose: shared types for the flash reset pin sequencer
// Assumes: nothing beyond the constants header
// Notes: the sequencer state order is not significant
package frs_pkg;
    typedef enum logic [2:0] {
        FRS_POR,
        FRS_POR_HELD,
        FRS_READY,
        FRS_HW_RESET,
        FRS_SW_RESET
    } frs_state_e;
    typedef logic [19:0] frs_count_t;
endpackage

//--- design/frs_pin_sync.sv
// Purpose: three-flop synchroniser for one asynchronous pin
// Assumes: input comes from outside the core clock domain
// Notes: the output changes only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module frs_pin_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic clock,
    input wire logic rstN,
    input wire logic pinIn,
    output logic pinOut
);
    logic [2:0] stage_q;
    logic out_q;

    // first stage feeds only the second, so no logic sees a metastable value
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            stage_q <= {3{RESET_VALUE}};
            out_q <= RESET_VALUE;
        end else begin
            stage_q <= {stage_q[1:0], pinIn};
            if (stage_q[2] == stage_q[1]) begin
                out_q <= stage_q[1];
            end
        end
    end

    assign pinOut = out_q;
endmodule
`default_nettype wire

//--- bench/frs_host_model.sv
// Purpose: host controller model driving select and the shared pin
// Assumes: tasks are entered 1 ns after a rising clock edge
// Notes: the pin is released unless a task drives it, so the pull-up decides
`timescale 1ns/1ps
`default_nettype none
module frs_host_model (
    input wire logic clock,
    output logic selectN,
    output logic pinOe,
    output logic pinVal
);
    // select stays high from time zero through power-up
    initial begin
        selectN = 1'b1;
        pinOe = 1'b0;
        pinVal = 1'b1;
    end
    // hold the pin at a level, or release it
    task automatic pin_set(input logic oe, input logic v);
        pinOe = oe;
        pinVal = v;
    endtask
    // reset pulse: drive high well past deselect time first, so no contention
    task automatic pin_pulse(input int n);
        pinOe = 1'b1;
        pinVal = 1'b1;
        repeat (20) @(posedge clock);
        #1 pinVal = 1'b0;
        repeat (n) @(posedge clock);
        #1 pinVal = 1'b1;
        @(posedge clock);
        #1 pinOe = 1'b0;
    endtask
    // one frame; after a write the host itself holds the pin high while deselected
    task automatic command(input int n, input logic isWrite);
        selectN = 1'b0;
        repeat (n) @(posedge clock);
        #1 selectN = 1'b1;
        if (isWrite) begin
            pin_set(1'b1, 1'b1);
        end
        repeat (13) @(posedge clock);
        #1 if (isWrite) begin
            pinOe = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench for the flash reset pin sequencer
// Assumes: shortened counts; the host model drives select and the pin
// Notes: monitor flags catch short pulses that a poll would miss
`timescale 1ns/1ps
`default_nettype none
`include "frs_consts.svh"
module tb;
    localparam int PU = 200;
    localparam int REC = 100;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic supplyGood = 1'b1;
    logic quadMode = 1'b0;
    logic quadReadDone = 1'b0;
    logic softResetCmd = 1'b0;
    logic resetPinEn = 1'b1;
    int driveCnt = 0;
    logic selectN, hostOe, hostVal, devOut, devOe, pinWire;
    logic deviceReady, regRestore, abortOps, outputsHiZ, commandBlock, porFailed;
    logic lowSeen = 1'b0;
    logic regSeen = 1'b0;
    logic driveSeen = 1'b0;
    int n_mismatch = 0;
    int num_checks = 0;
    int n;
    int w;
    // wire level: host, then device, else the internal pull-up holds it high
    assign pinWire = hostOe ? hostVal : (devOe ? devOut : 1'b1);
    frs_host_model host (.clock(clock), .selectN(selectN), .pinOe(hostOe), .pinVal(hostVal));
    frs_reset_sequencer #(.POWER_UP_CYC(PU), .RECOVERY_CYC(REC)) DUT (
        .clock(clock), .reset_n(reset_n), .supplyGood(supplyGood), .selectNPin(selectN),
        .sharedPinAIn(pinWire), .sharedPinAPullEn(!hostOe && !devOe), .sharedPinAOut(devOut),
        .sharedPinAOe(devOe), .quadModeEnableBit(quadMode), .resetPinEnableBit(resetPinEn),
        .quadReadDone(quadReadDone), .softResetCmd(softResetCmd),
        .deviceReady(deviceReady), .regRestore(regRestore), .abortOps(abortOps),
        .outputsHiZ(outputsHiZ), .commandBlock(commandBlock), .porFailed(porFailed));
    initial begin
        forever #2 clock = ~clock;
    end
    // sticky flags, cleared by the main sequence
    always @(posedge clock) begin
        if (deviceReady !== 1'b1) lowSeen <= 1'b1;
        if (regRestore === 1'b1) regSeen <= 1'b1;
        if (devOe === 1'b1 && devOut === 1'b1) driveSeen <= 1'b1;
        if (devOe === 1'b1) driveCnt <= driveCnt + 1;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic clr();
        lowSeen = 1'b0;
        regSeen = 1'b0;
        driveSeen = 1'b0;
        driveCnt = 0;
    endtask
    task automatic chk(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    task automatic chk_span(input int got, input int lo, input int hi, input string msg);
        num_checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s n=%0d", $time, msg, got);
        end
    endtask
    task automatic wait_ready(output int k);
        k = 0;
        while (deviceReady !== 1'b1 && k < 1000) begin
            @(posedge clock);
            k++;
        end
        #1;
    endtask
    // cycles left after a pulse of w: sync and count take about 53 of them
    function automatic int exp_left(input logic failed, input int w);
        return (failed ? PU : REC) + 53 - w;
    endfunction
    // cycles of pin drive after a quad read: the deselect time, longer with pin reset on
    function automatic int exp_drive(input int r);
        if (r == 0) begin
            return 0;
        end
        return (r == 1) ? `FRS_DESEL_LONG_CYC : `FRS_DESEL_CYC;
    endfunction
    task print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h4b5f));
        host.pin_set(1'b1, 1'b0);
        cyc(16);
        reset_n = 1'b1;
        cyc(PU + 40);
        chk(deviceReady, 1'b0, "ready while pin held low");
        host.pin_set(1'b0, 1'b1);
        wait_ready(n);
        chk_span(n, 0, 20, "slow ready after pin high");
        // short pulses must pass unnoticed
        cyc(10);
        clr();
        host.pin_pulse(5 + $urandom % 40);
        cyc(10);
        chk(lowSeen, 1'b0, "glitch caused reset");
        w = 55 + $urandom % 20;
        clr();
        host.pin_pulse(w);
        chk(abortOps, 1'b1, "no abort");
        chk(outputsHiZ, 1'b1, "outputs driven");
        chk(commandBlock, 1'b1, "commands accepted");
        chk(regSeen, 1'b1, "no register restore");
        wait_ready(n);
        chk_span(n, exp_left(0, w) - 10, exp_left(0, w) + 10, "recovery length");
        cyc(30);
        clr();
        softResetCmd = 1'b1;
        cyc(1);
        softResetCmd = 1'b0;
        cyc(3);
        chk(deviceReady, 1'b0, "soft reset ignored");
        wait_ready(n);
        chk_span(n, REC - 10, REC + 5, "soft reset length");
        // pin low while selected: data in quad mode, reset otherwise
        for (int q = 1; q >= 0; q--) begin
            quadMode = q[0];
            cyc(30);
            clr();
            fork
                host.command(90, 1'b0);
                begin
                    cyc(2);
                    host.pin_pulse(60);
                end
            join
            chk(lowSeen, q == 0, "pin reset while selected");
            wait_ready(n);
        end
        quadMode = 1'b1;
        // r: no read, read with pin reset on (long deselect), read with it off
        for (int r = 0; r < 3; r++) begin
            quadReadDone = r != 0;
            resetPinEn = r != 2;
            cyc(10);
            clr();
            host.command(8, 1'b0);
            chk(driveSeen, r != 0, "pin drive after frame");
            chk(devOe, 1'b0, "pin still driven");
            chk_span(driveCnt, exp_drive(r) - 1, exp_drive(r) + 1, "drive length");
        end
        quadReadDone = 1'b0;
        resetPinEn = 1'b1;
        host.command(8, 1'b1);
        // supply dip during power-on marks it failed
        reset_n = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        cyc(100);
        supplyGood = 1'b0;
        cyc(5);
        supplyGood = 1'b1;
        cyc(2);
        chk(porFailed, 1'b1, "failed power-on not flagged");
        wait_ready(n);
        chk_span(n, PU - 10, PU + 20, "power-up length");
        chk(porFailed, 1'b1, "failed flag lost before reset");
        host.pin_pulse(60);
        wait_ready(n);
        chk_span(n, exp_left(1, 60) - 10, exp_left(1, 60) + 10, "full power-on");
        chk(porFailed, 1'b0, "failed flag kept after full power-on");
        print_verdict();
    end
endmodule
`default_nettype wire
